/* dv/umb_modem_model.sv */
/*
  Far-end modem model: drives modem pins, delivers received characters
  and drains the transmit queue slowly. Assumes the block's clock.
*/
`timescale 1ns/100ps
module umb_modem_model (
  input wire logic clk_in,
  input wire umb_pkg::umb_modem_s lines_in,
  input wire logic send_in,
  input wire umb_pkg::umb_rx_char_s char_in,
  input wire logic tx_valid_in,
  output logic [3:0] pins_n_out,
  output logic rx_valid_out,
  output umb_pkg::umb_rx_char_s rx_char_out,
  output logic tx_take_out,
  output logic tx_idle_out
);
  import umb_pkg::*;
  logic [2:0] wait_q = 3'h0;
  initial begin
    pins_n_out = 4'hF;
    rx_valid_out = 1'b0;
    rx_char_out = '0;
    tx_take_out = 1'b0;
    tx_idle_out = 1'b1;
  end
  always @(posedge clk_in) begin
    pins_n_out <= ~lines_in;
    rx_valid_out <= send_in;
    // idle data bus inverts its last value every cycle, so it alternates with the last character
    rx_char_out <= send_in ? char_in : ~rx_char_out;
    wait_q <= tx_valid_in ? wait_q + 3'h1 : 3'h0;
    tx_take_out <= tx_valid_in && wait_q == 3'h6;
    tx_idle_out <= !tx_valid_in;
  end
endmodule

/* dv/umb_uart_channel_chk.sv */
/*
  Port-level assertions of the serial channel block.
  Assumes binding into the block: one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module umb_uart_channel_chk #(
  parameter int AW = 12
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic request_to_send_n_out,
  input wire logic [7:0] tx_char_out,
  input wire logic tx_char_valid_out,
  input wire logic [7:0] line_ctl_out,
  input wire logic loopback_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire acc_w = psel_in && penable_in && pready_out;
  wire mcr_wr = acc_w && pwrite_in && paddr_in == 12'h010;
  wire [7:0] wbyte = pwdata_in[7:0];
  wire wd_loop = pwdata_in[4];
  wire wd_rts = pwdata_in[1];
  ////////////////
  pready_gate_a: assert property (pready_out |-> psel_in && penable_in && clk_en_in)
    else $error("pready outside an access");
  zero_wait_a: assert property (psel_in && !penable_in && clk_en_in ##1 psel_in && penable_in && clk_en_in
    |-> pready_out) else $error("access not answered at once");
  err_map_a: assert property (acc_w |-> pslverr_out == (paddr_in[AW-1:5] != '0 || paddr_in[1:0] != 2'h0))
    else $error("error response does not match address map");
  upper_zero_a: assert property (prdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  tx_idle_a: assert property (!tx_char_valid_out |-> tx_char_out == 8'h00)
    else $error("empty queue shows data");
  lcr_copy_a: assert property (acc_w && pwrite_in && paddr_in == 12'h00C |=> line_ctl_out == $past(wbyte))
    else $error("line control not updated");
  loop_follow_a: assert property (mcr_wr |=> loopback_out == $past(wd_loop))
    else $error("loopback does not follow control write");
  modem_out_a: assert property (mcr_wr |-> ##2 request_to_send_n_out == (!$past(wd_rts, 2) || $past(wd_loop, 2)))
    else $error("request to send pin wrong");
endmodule

/* dv/umb_uart_channel_test.sv */
/*
  Self-checking bench of the serial channel block over APB.
  Assumes the package, design, checker and modem model compiled first.
*/
`timescale 1ns/100ps
module umb_uart_channel_test;
  import umb_pkg::*;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, clk_en_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, send = 1'b0, errv;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdv, t, z;
  logic pready_out, pslverr_out, terminal_ready_n_out, request_to_send_n_out;
  logic user_output_one_n_out, user_output_two_n_out, rx_char_valid_in, tx_char_valid_out;
  logic tx_char_take_in, tx_shift_empty_in, loopback_out, baud_tick_out, baud_clk_out, uart_irq_out;
  wire clear_to_send_n_in, set_ready_n_in, ring_n_in, carrier_n_in;
  logic [7:0] tx_char_out, line_ctl_out;
  umb_rx_char_s rx_char_in, chr = '0;
  umb_modem_s lines = '0;
  int fails = 0, total_checks = 0;
  logic [7:0] mv [5] = '{8'h1, 8'h3, 8'h7, 8'h3, 8'hB};
  logic [7:0] me [5] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hB8};
  logic [7:0] bd [3] = '{8'h05, 8'h00, 8'h02};
  logic [31:0] et [3] = '{32'hC, 32'h14, 32'h1E};
  logic [31:0] ez [3] = '{32'h18, 32'h28, 32'h1E};
  umb_uart_channel umb_uart_channel_i (.*);
  umb_modem_model umb_modem_model_i (.clk_in(clk_sys_in), .lines_in(lines), .send_in(send), .char_in(chr),
    .tx_valid_in(tx_char_valid_out), .pins_n_out({carrier_n_in, ring_n_in, set_ready_n_in, clear_to_send_n_in}),
    .rx_valid_out(rx_char_valid_in), .rx_char_out(rx_char_in), .tx_take_out(tx_char_take_in),
    .tx_idle_out(tx_shift_empty_in));
  ////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each transfer keeps drivers single-assigned per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      test_done();
    end
    rdv = prdata_out;
    errv = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rdv, {24'h0, e});
  endtask
  task automatic put(input logic [10:0] c);
    chr <= c;
    send <= 1'b1;
    @(posedge clk_sys_in);
    send <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (uart_irq_out !== 1'b1 && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
    check(32'(uart_irq_out), 32'h1);
    if (n >= lim) test_done();
  endtask
  ////////////////
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(12'h014, 8'h60);
    rd(12'h008, 8'h01);
    apb(1'b1, 12'h01C, 8'hA5);
    rd(12'h01C, 8'hA5);
    apb(1'b1, 12'h020, 8'h00);
    check(32'(errv), 32'h1);
    apb(1'b1, 12'h010, 8'h08);
    apb(1'b1, 12'h004, 8'h08);
    foreach (mv[i]) begin
      lines <= umb_modem_s'(mv[i][3:0]);
      repeat (6) @(posedge clk_sys_in);
      check(32'(uart_irq_out), 32'(me[i][3:0] != 4'h0));
      rd(12'h018, me[i]);
      rd(12'h018, me[i] & 8'hF0);
    end
    apb(1'b1, 12'h010, 8'h1A);
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, 12'h018, 8'h00);
    rd(12'h018, 8'h90);
    apb(1'b1, 12'h010, 8'h08);
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, 12'h018, 8'h00);
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h00C, 8'h80);
    apb(1'b1, 12'h000, 8'h30);
    apb(1'b1, 12'h004, 8'h00);
    rd(12'h000, 8'h30);
    rd(12'h004, 8'h00);
    foreach (bd[i]) begin
      apb(1'b1, 12'h00C, 8'h80);
      apb(1'b1, 12'h000, bd[i]);
      apb(1'b1, 12'h004, 8'h00);
      rd(12'h000, bd[i]);
      rd(12'h01C, 8'hA5);
      apb(1'b1, 12'h00C, 8'h03);
      t = 32'h0;
      z = 32'h0;
      repeat (60) begin
        @(posedge clk_sys_in);
        t = t + 32'(baud_tick_out);
        z = z + 32'(!baud_clk_out);
      end
      check(t, et[i]);
      check(z, ez[i]);
    end
    apb(1'b1, 12'h008, 8'h41);
    put(11'h055);
    rd(12'h014, 8'h61);
    rd(12'h008, 8'hC1);
    apb(1'b1, 12'h004, 8'h01);
    repeat (2) put(11'h0AA);
    rd(12'h008, 8'hC1);
    put(11'h033);
    rd(12'h008, 8'hC4);
    rd(12'h000, 8'h55);
    rd(12'h008, 8'hC1);
    repeat (3) apb(1'b0, 12'h000, 8'h00);
    rd(12'h014, 8'h60);
    put(11'h07E);
    repeat (1200) @(posedge clk_sys_in);
    rd(12'h008, 8'hC1);
    wait_irq(300);
    rd(12'h008, 8'hCC);
    rd(12'h000, 8'h7E);
    rd(12'h008, 8'hC1);
    apb(1'b1, 12'h004, 8'h05);
    apb(1'b1, 12'h008, 8'h01);
    put(11'h1F0);
    rd(12'h008, 8'hC6);
    rd(12'h014, 8'hE5);
    rd(12'h000, 8'hF0);
    rd(12'h014, 8'h60);
    rd(12'h008, 8'hC1);
    apb(1'b1, 12'h004, 8'h02);
    rd(12'h008, 8'hC2);
    rd(12'h008, 8'hC1);
    apb(1'b1, 12'h000, 8'h3C);
    check({24'h0, tx_char_out}, 32'h3C);
    wait_irq(600);
    rd(12'h008, 8'hC2);
    apb(1'b1, 12'h000, 8'h11);
    rd(12'h008, 8'hC1);
    test_done();
  end
endmodule

bind umb_uart_channel umb_uart_channel_chk #(.AW(AW)) umb_uart_channel_chk_i (.*);

/* hdl/umb_params.svh */
/*
  Offsets, field positions, reset values and timing counts of the serial
  channel block. Assumes inclusion by bare name from the design files.
*/
`ifndef UMB_PARAMS_SVH
`define UMB_PARAMS_SVH

// register indices, byte address is four times the index
`define UMB_IDX_DATA 3'h0
`define UMB_IDX_IER 3'h1
`define UMB_IDX_IIR 3'h2
`define UMB_IDX_LCR 3'h3
`define UMB_IDX_MCR 3'h4
`define UMB_IDX_LSR 3'h5
`define UMB_IDX_MSR 3'h6
`define UMB_IDX_SCR 3'h7

// field positions
`define UMB_LCR_DLAB 7
`define UMB_MCR_LOOP 4
`define UMB_FCR_EN 0
`define UMB_FCR_RXRST 1
`define UMB_FCR_TXRST 2

// interrupt identity codes
`define UMB_IID_NONE 4'h1
`define UMB_IID_LS 4'h6
`define UMB_IID_RDA 4'h4
`define UMB_IID_TO 4'hC
`define UMB_IID_THR 4'h2
`define UMB_IID_MS 4'h0

// reset values
`define UMB_RST_BYTE 8'h00
`define UMB_RST_DIV 16'h0000

// timing: bit length in 16x ticks, timeout in characters, divisor-0 period in input clocks
`define UMB_TICKS_PER_BIT 8'h10
`define UMB_TO_CHARS 4'h4
`define UMB_DIV_ZERO_PERIOD 16'h0003

`endif

/* hdl/umb_pkg.sv */
/*
  Types shared by the serial channel block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package umb_pkg;
  // one received character with its error marks
  typedef struct packed {
    logic brk;
    logic frame_err;
    logic parity_err;
    logic [7:0] data;
  } umb_rx_char_s;

  // modem control lines, active high sense
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_to_send;
  } umb_modem_s;

  typedef logic [3:0] umb_iid_t;
endpackage

/* hdl/umb_uart_channel.sv */
/*
  Serial channel register block: modem status, scratch byte, baud
  generator, receive and transmit queues with their interrupts, on APB.
  Assumes shift logic on the same clock feeding received characters and
  taking transmit characters; modem pins arrive asynchronously.
*/
//
// Functional notes
// - set_ready change flag sets when set_ready input toggled since last status read.
// - ring trailing-edge flag sets only when ring input goes low to high.
// - carrier change flag sets whenever carrier input changes.
// - any of the four change flags raises the modem status interrupt.
// - status bits 4-7 show inverted inputs; loopback shows control bits instead.
// - scratch byte at offset 7, any divisor select, no side effects.
// - baud generator divides by 16-bit divisor held in low and high latches.
// - generator output is the 16x bit sampling clock.
// - writing either divisor latch reloads the baud counter at once.
// - divisor 0 divides by 3, 1 holds the output high with a tick every cycle, 2 is half rate.
// - divisors of 3 up: output low two input clocks, then high.
// - receive data interrupt and code follow the trigger level.
// - line status interrupt 06H outranks received data 04H.
// - data ready sets on first queued character, clears when queue empty.
// - timeout interrupt after four idle character times with data queued.
// - character times are counted in receive sampling clock ticks.
// - reading one character clears a pending timeout and restarts timer.
// - with no timeout pending, arrivals and reads restart the timer.
// - holding-empty interrupt on empty queue, cleared by write or identity read.
// - with queues enabled, empty indication delayed one character less the last stop bit unless two bytes were held.
// - timeout shares received-data level, queue empty shares holding-empty level.
// - with enables clear the channel runs polled through line status.
// - reading modem status clears all four change flags.
// - clear_to_send change flag sets when that input toggled since last read.
`timescale 1ns/100ps
`include "umb_params.svh"

module umb_uart_channel #(
  parameter int DEPTH = 16,
  parameter int AW = 12
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic clear_to_send_n_in,
  input wire logic set_ready_n_in,
  input wire logic ring_n_in,
  input wire logic carrier_n_in,
  output logic terminal_ready_n_out,
  output logic request_to_send_n_out,
  output logic user_output_one_n_out,
  output logic user_output_two_n_out,
  input wire logic rx_char_valid_in,
  input wire umb_pkg::umb_rx_char_s rx_char_in,
  output logic [7:0] tx_char_out,
  output logic tx_char_valid_out,
  input wire logic tx_char_take_in,
  input wire logic tx_shift_empty_in,
  output logic [7:0] line_ctl_out,
  output logic loopback_out,
  output logic baud_tick_out,
  output logic baud_clk_out,
  output logic uart_irq_out
);
  import umb_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] dll_q, dlh_q, ier_q, lcr_q, mcr_q, scr_q;
  logic fifo_en_q;
  logic [1:0] trig_sel_q;
  logic setup_q;
  logic [31:0] rdata_q;
  logic oe_q, thr_int_q, two_held_q, timeout_q;
  logic dly_act_q;
  logic [7:0] dly_cnt_q;
  logic [9:0] to_cnt_q;
  logic [15:0] baud_cnt_q;
  logic baud_lvl_q, baud_tick_q;
  logic [3:0] sync1_q, sync2_q;
  logic [3:0] mstate_q, mflag_q;
  logic [3:0] mout_q;
  umb_rx_char_s rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
  logic [CW-1:0] rx_cnt_q, tx_cnt_q, err_cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire [2:0] idx = paddr_in[4:2];
  wire unmapped = (|paddr_in[AW-1:5]) | (|paddr_in[1:0]);
  wire dlab = lcr_q[`UMB_LCR_DLAB];
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & setup_q & clk_en_in;
  wire wr = access & pwrite_in & ~unmapped;
  wire rd = access & ~pwrite_in & ~unmapped;
  wire [7:0] wdat = pwdata_in[7:0];
  wire at_data = idx == `UMB_IDX_DATA;
  wire at_ier = idx == `UMB_IDX_IER;
  wire wr_thr = wr & at_data & ~dlab;
  wire wr_dll = wr & at_data & dlab;
  wire wr_dlh = wr & at_ier & dlab;
  wire wr_ier = wr & at_ier & ~dlab;
  wire wr_fcr = wr & (idx == `UMB_IDX_IIR);
  wire rd_rbr = rd & at_data & ~dlab;
  wire rd_iir = rd & (idx == `UMB_IDX_IIR);
  wire rd_lsr = rd & (idx == `UMB_IDX_LSR);
  wire rd_msr = rd & (idx == `UMB_IDX_MSR);
  wire fifo_flip = wr_fcr & (wdat[`UMB_FCR_EN] != fifo_en_q);

  //////////////////////////////////////////////////////////////////////////
  // baud generator
  wire [15:0] divisor = {dlh_q, dll_q};
  wire [15:0] period = (divisor == 16'h0000) ? `UMB_DIV_ZERO_PERIOD : divisor;
  wire [15:0] new_div = wr_dll ? {dlh_q, wdat} : {wdat, dll_q};
  wire [15:0] new_per = (new_div == 16'h0000) ? `UMB_DIV_ZERO_PERIOD : new_div;
  wire div_wr = wr_dll | wr_dlh;
  wire baud_wrap = baud_cnt_q == 16'h0000;
  wire [15:0] baud_cnt_d = div_wr ? new_per - 16'h0001 :
                           baud_wrap ? period - 16'h0001 : baud_cnt_q - 16'h0001;
  wire [15:0] cnt_up_d = period - 16'h0001 - baud_cnt_d;
  // divide by one cannot invert the clock in flops; output stays high, tick every cycle
  wire baud_lvl_d = (period == 16'h0001) ? 1'b1 :
                    (period == 16'h0002) ? baud_cnt_d[0] :
                    (cnt_up_d >= 16'h0002);
  wire tick = baud_tick_q;

  //////////////////////////////////////////////////////////////////////////
  // character timing in 16x ticks
  wire [3:0] char_bits = 4'h1 + 4'h5 + {2'b00, lcr_q[1:0]} + {3'b000, lcr_q[3]}
                         + 4'h1 + {3'b000, lcr_q[2]};
  wire [9:0] to_limit = {char_bits, 6'h00}; // four chars, 16 ticks per bit
  wire [7:0] dly_limit = {char_bits - 4'h1, 4'h0}; // minus the last stop bit

  //////////////////////////////////////////////////////////////////////////
  // receive queue
  wire [CW-1:0] rx_cap = fifo_en_q ? CW'(DEPTH) : CW'(1);
  wire rx_empty = rx_cnt_q == '0;
  wire rx_full = rx_cnt_q >= rx_cap;
  wire rx_push = rx_char_valid_in & ~rx_full;
  wire rx_pop = rd_rbr & ~rx_empty;
  wire rx_clr = fifo_flip | (wr_fcr & wdat[`UMB_FCR_RXRST]);
  umb_rx_char_s head;
  assign head = rx_empty ? '0 : rx_mem[rx_rd_q];
  wire push_err = rx_char_in.brk | rx_char_in.frame_err | rx_char_in.parity_err;
  wire head_err = head.brk | head.frame_err | head.parity_err;
  wire [CW-1:0] trig_lvl = (trig_sel_q == 2'b00) ? CW'(1) : (trig_sel_q == 2'b01) ? CW'(4) :
                           (trig_sel_q == 2'b10) ? CW'(8) : CW'(14);

  //////////////////////////////////////////////////////////////////////////
  // transmit queue
  wire [CW-1:0] tx_cap = fifo_en_q ? CW'(DEPTH) : CW'(1);
  wire tx_empty = tx_cnt_q == '0;
  wire tx_push = wr_thr & (tx_cnt_q < tx_cap);
  wire tx_pop = tx_char_take_in & ~tx_empty & clk_en_in;
  wire tx_clr = fifo_flip | (wr_fcr & wdat[`UMB_FCR_TXRST]);
  wire went_empty = tx_pop & ~tx_push & (tx_cnt_q == CW'(1));
  wire dly_done = dly_act_q & tick & (dly_cnt_q + 8'h01 >= dly_limit);

  //////////////////////////////////////////////////////////////////////////
  // modem lines
  wire [3:0] pins_now = ~sync2_q; // active high {carrier,ring,set_ready,cts}
  wire loop = mcr_q[`UMB_MCR_LOOP];
  wire [3:0] loop_state = {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]};
  wire [3:0] mstate_d = loop ? loop_state : pins_now;
  wire [3:0] mdelta;
  assign mdelta[0] = mstate_d[0] ^ mstate_q[0];
  assign mdelta[1] = mstate_d[1] ^ mstate_q[1];
  assign mdelta[2] = mstate_q[2] & ~mstate_d[2];
  assign mdelta[3] = mstate_d[3] ^ mstate_q[3];
  wire [3:0] mflag_d = mdelta | (rd_msr ? 4'h0 : mflag_q);
  wire [3:0] mout_d = loop ? 4'h0 : mcr_q[3:0]; // pins idle high in loopback

  //////////////////////////////////////////////////////////////////////////
  // interrupt identity, polled when enables are clear
  wire ls_int = ier_q[2] & (oe_q | head_err);
  wire rda_int = ier_q[0] & (rx_cnt_q >= (fifo_en_q ? trig_lvl : CW'(1)));
  wire to_int = ier_q[0] & fifo_en_q & timeout_q;
  wire thr_int = ier_q[1] & thr_int_q;
  wire ms_int = ier_q[3] & (|mflag_q);
  umb_iid_t iid;
  assign iid = ls_int ? `UMB_IID_LS :
               rda_int ? `UMB_IID_RDA :
               to_int ? `UMB_IID_TO :
               thr_int ? `UMB_IID_THR :
               ms_int ? `UMB_IID_MS : `UMB_IID_NONE;
  wire thr_set = (went_empty & (two_held_q | ~fifo_en_q)) | dly_done
                 | fifo_flip | (wr_ier & wdat[1] & ~ier_q[1] & tx_empty);
  wire thr_clr = wr_thr | (rd_iir & (iid == `UMB_IID_THR));

  wire [7:0] line_state = {fifo_en_q & (err_cnt_q != '0), tx_empty & tx_shift_empty_in,
                    tx_empty, head.brk, head.frame_err, head.parity_err, oe_q,
                    ~rx_empty};
  wire [7:0] interrupt_identity = {fifo_en_q, fifo_en_q, 2'b00, iid};
  logic [7:0] rmux;
  always_comb begin
    case (idx)
      `UMB_IDX_DATA: rmux = dlab ? dll_q : head.data;
      `UMB_IDX_IER: rmux = dlab ? dlh_q : ier_q;
      `UMB_IDX_IIR: rmux = interrupt_identity;
      `UMB_IDX_LCR: rmux = lcr_q;
      `UMB_IDX_MCR: rmux = mcr_q;
      `UMB_IDX_LSR: rmux = line_state;
      `UMB_IDX_MSR: rmux = {mstate_q, mflag_q};
      `UMB_IDX_SCR: rmux = scr_q;
      default: rmux = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // bus and control registers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      setup_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      setup_q <= setup;
      if (setup) begin
        rdata_q <= unmapped ? 32'h0000_0000 : {24'h00_0000, rmux};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dll_q <= `UMB_RST_BYTE;
      dlh_q <= `UMB_RST_BYTE;
      ier_q <= `UMB_RST_BYTE;
      lcr_q <= `UMB_RST_BYTE;
      mcr_q <= `UMB_RST_BYTE;
      scr_q <= `UMB_RST_BYTE;
      fifo_en_q <= 1'b0;
      trig_sel_q <= 2'b00;
    end else if (clk_en_in) begin
      if (wr_dll) begin
        dll_q <= wdat;
      end
      if (wr_dlh) begin
        dlh_q <= wdat;
      end
      if (wr_ier) begin
        ier_q <= {4'h0, wdat[3:0]};
      end
      if (wr & (idx == `UMB_IDX_LCR)) begin
        lcr_q <= wdat;
      end
      if (wr & (idx == `UMB_IDX_MCR)) begin
        mcr_q <= {3'b000, wdat[4:0]};
      end
      if (wr & (idx == `UMB_IDX_SCR)) begin
        scr_q <= wdat;
      end
      if (wr_fcr) begin
        fifo_en_q <= wdat[`UMB_FCR_EN];
        trig_sel_q <= wdat[7:6];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // baud generator state
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      baud_cnt_q <= `UMB_RST_DIV;
      baud_lvl_q <= 1'b1;
      baud_tick_q <= 1'b0;
    end else if (clk_en_in) begin
      baud_cnt_q <= baud_cnt_d;
      baud_lvl_q <= baud_lvl_d;
      baud_tick_q <= baud_wrap & ~div_wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // queue storage and receive queue state
  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in & rx_push) begin
      rx_mem[rx_wr_q] <= rx_char_in;
    end
    if (clk_en_in & tx_push) begin
      tx_mem[tx_wr_q] <= wdat;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      rx_cnt_q <= '0;
      err_cnt_q <= '0;
      oe_q <= 1'b0;
    end else if (clk_en_in) begin
      if (rx_clr) begin
        rx_wr_q <= '0;
        rx_rd_q <= '0;
        rx_cnt_q <= '0;
        err_cnt_q <= '0;
      end else begin
        if (rx_push) begin
          rx_wr_q <= PW'(rx_wr_q + 1'b1);
        end
        if (rx_pop) begin
          rx_rd_q <= PW'(rx_rd_q + 1'b1);
        end
        rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
        err_cnt_q <= err_cnt_q + CW'(rx_push & push_err) - CW'(rx_pop & head_err);
      end
      // a full queue drops the character; overrun wins over the read clear
      oe_q <= (rx_char_valid_in & rx_full) | (oe_q & ~rd_lsr);
    end
  end

  // timeout timer on 16x ticks
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      to_cnt_q <= 10'h000;
      timeout_q <= 1'b0;
    end else if (clk_en_in) begin
      if (rx_push | rx_pop | rx_clr | rx_empty) begin
        to_cnt_q <= 10'h000;
      end else if (tick & ~timeout_q) begin
        to_cnt_q <= to_cnt_q + 10'h001;
      end
      if (rx_pop | rx_clr | rx_empty) begin
        timeout_q <= 1'b0;
      end else if (to_cnt_q >= to_limit) begin
        timeout_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit queue state
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_wr_q <= '0;
      tx_rd_q <= '0;
      tx_cnt_q <= '0;
    end else if (clk_en_in) begin
      if (tx_clr) begin
        tx_wr_q <= '0;
        tx_rd_q <= '0;
        tx_cnt_q <= '0;
      end else begin
        if (tx_push) begin
          tx_wr_q <= PW'(tx_wr_q + 1'b1);
        end
        if (tx_pop) begin
          tx_rd_q <= PW'(tx_rd_q + 1'b1);
        end
        tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
      end
    end
  end

  // holding-empty interrupt with its character-time delay
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      thr_int_q <= 1'b0;
      two_held_q <= 1'b0;
      dly_act_q <= 1'b0;
      dly_cnt_q <= 8'h00;
    end else if (clk_en_in) begin
      thr_int_q <= thr_set | (thr_int_q & ~thr_clr);
      if (thr_set) begin
        two_held_q <= 1'b0;
      end else if (tx_cnt_q >= CW'(2)) begin
        two_held_q <= 1'b1;
      end
      if (went_empty & fifo_en_q & ~two_held_q) begin
        dly_act_q <= 1'b1;
        dly_cnt_q <= 8'h00;
      end else if (tx_push | dly_done | tx_clr) begin
        dly_act_q <= 1'b0;
      end else if (dly_act_q & tick) begin
        dly_cnt_q <= dly_cnt_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // modem synchroniser and change flags
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      mstate_q <= 4'h0;
      mflag_q <= 4'h0;
      mout_q <= 4'h0;
    end else if (clk_en_in) begin
      sync1_q <= {carrier_n_in, ring_n_in, set_ready_n_in, clear_to_send_n_in};
      sync2_q <= sync1_q;
      mstate_q <= mstate_d;
      mflag_q <= mflag_d;
      mout_q <= mout_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_out = rdata_q;
  assign pready_out = psel_in & penable_in & setup_q & clk_en_in;
  assign pslverr_out = pready_out & unmapped;
  assign terminal_ready_n_out = ~mout_q[0];
  assign request_to_send_n_out = ~mout_q[1];
  assign user_output_one_n_out = ~mout_q[2];
  assign user_output_two_n_out = ~mout_q[3];
  assign tx_char_out = tx_empty ? 8'h00 : tx_mem[tx_rd_q];
  assign tx_char_valid_out = ~tx_empty;
  assign line_ctl_out = lcr_q;
  assign loopback_out = loop;
  assign baud_tick_out = baud_tick_q;
  assign baud_clk_out = baud_lvl_q;
  // user output two gates the interrupt line
  assign uart_irq_out = mcr_q[3] & (iid != `UMB_IID_NONE);
endmodule
